// ==== bdsl_link.sv ====
// Target end of the single-wire background debug serial link
module bdsl_link
  import bdsl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_serial_clock_select,
  input wire logic i_pin,
  output logic o_pin_out,
  output logic o_pin_oe,
  input wire logic i_ack_enable,
  input wire logic i_system_stop,
  input wire logic i_cpu_stopwait,
  input wire logic i_ext_wait,
  output logic o_bus_req,
  output logic o_bus_we,
  output logic o_bus_map,
  output logic [15:0] o_bus_addr,
  output logic [1:0] o_bus_be,
  output logic [15:0] o_bus_wdata,
  input wire logic i_bus_ack,
  input wire logic [15:0] i_bus_rdata,
  output logic o_fw_req,
  output logic [7:0] o_fw_opcode,
  output logic [15:0] o_fw_wdata,
  input wire logic i_fw_done,
  input wire logic [15:0] i_fw_rdata,
  output logic o_timeout
);

  bdsl_state_t state_reg, state_next;
  bdsl_cls_t cls_reg, cls_next;
  logic sync1_reg, sync2_reg, sync3_reg;
  logic [1:0] div_reg, div_next;
  logic [4:0] tcnt_reg, tcnt_next;
  logic bact_reg, bact_next;
  logic [3:0] bitn_reg, bitn_next;
  logic [15:0] sh_reg, sh_next;
  logic hi8_reg, hi8_next;
  logic [7:0] op_reg, op_next;
  logic [15:0] addr_reg, addr_next;
  logic [15:0] wdat_reg, wdat_next;
  logic [5:0] dly_reg, dly_next;
  logic [9:0] to_reg, to_next;
  logic pin_out_next, pin_oe_next;
  logic bus_req_next, fw_req_next;

  // ----------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------
  function automatic bdsl_cls_t decode(input logic [7:0] op);
    bdsl_cls_t c;
    c = CL_NONE;
    if (op[7:4] == HW_READ_TOP && op[1:0] == HW_LOW_BITS) begin
      c = CL_HWR;
    end else if (op[7:4] == HW_WRITE_TOP && op[1:0] == HW_LOW_BITS) begin
      c = CL_HWW;
    end else if (op[7:3] == FW_READ_TOP && op[2:0] >= FW_REG_MIN) begin
      c = CL_FWR;
    end else if (op[7:3] == FW_WRITE_TOP && op[2:0] >= FW_REG_MIN) begin
      c = CL_FWW;
    end else if (op == OPC_GO || op == OPC_GO_UNTIL || op == OPC_STEP ||
                 op == OPC_GO_OLD) begin
      c = CL_CTL;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Edge recognition and target clock
  // ----------------------------------------------------------------
  wire logic tick;
  wire logic [4:0] tnext;
  wire logic fall;
  assign tick = i_serial_clock_select || (div_reg == ALT_DIV_LAST);
  assign tnext = tcnt_reg + 5'h01;
  assign fall = sync3_reg && !sync2_reg;

  // Tick count within a bit reaches n on this tick
  function automatic logic at_tick(input logic tk, input logic act,
      input logic [4:0] nxt, input logic [4:0] n);
    return tk && act && (nxt == n);
  endfunction

  // ----------------------------------------------------------------
  // Field and command decode
  // ----------------------------------------------------------------
  wire logic rx_state, tx_state, shift_state, start_bit, bit_done;
  wire logic field_done, abort, to_hit, is_read, is_hw, ack_go;
  wire logic blocked_wr, hw_done, fw_done, done, is_word;
  wire logic [15:0] even_addr, rd_raw, rd_word;
  wire bdsl_cls_t op_cls;
  assign rx_state = state_reg == BDSL_OPC || state_reg == BDSL_ADDR ||
                    state_reg == BDSL_WDATA;
  assign tx_state = state_reg == BDSL_RDATA;
  assign shift_state = rx_state || tx_state;
  assign start_bit = fall && shift_state && !bact_reg;
  assign bit_done = at_tick(tick, bact_reg, tnext, BIT_TICKS);
  assign field_done = bit_done && (bitn_reg ==
                      ((state_reg == BDSL_OPC) ? OPC_LAST_BIT : WORD_LAST_BIT));
  assign abort = fall && (state_reg == BDSL_EXEC ||
                          state_reg == BDSL_ACKDLY);
  assign to_hit = tick && shift_state &&
                  (to_reg == TIMEOUT_TICKS - 10'h001);
  assign op_cls = decode(sh_reg[7:0]);
  assign is_read = cls_reg == CL_HWR || cls_reg == CL_FWR;
  assign is_hw = cls_reg == CL_HWR || cls_reg == CL_HWW;
  assign is_word = op_reg[OP_WORD_BIT];
  assign even_addr = {addr_reg[15:1], 1'b0};
  assign blocked_wr = cls_reg == CL_HWW && op_reg[OP_MAP_BIT] &&
                      even_addr >= FW_AREA_LO && even_addr <= FW_AREA_HI;
  assign hw_done = (o_bus_req && i_bus_ack) ||
                   (state_reg == BDSL_EXEC && blocked_wr);
  assign fw_done = o_fw_req && i_fw_done;
  assign done = is_hw ? hw_done : fw_done;
  assign rd_raw = is_hw ? i_bus_rdata : i_fw_rdata;
  assign rd_word = (!is_hw || is_word) ? rd_raw :
                   (addr_reg[0] ? {8'h00, rd_raw[7:0]} :
                                  {rd_raw[15:8], 8'h00});
  assign ack_go = i_ack_enable && !i_system_stop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cls_next = cls_reg;
    case (state_reg)
      BDSL_OPC: begin
        if (field_done) begin
          cls_next = op_cls;
          case (op_cls)
            CL_HWR, CL_HWW: state_next = BDSL_ADDR;
            CL_FWW: state_next = BDSL_WDATA;
            CL_FWR, CL_CTL: state_next = BDSL_EXEC;
            default: state_next = BDSL_OPC;
          endcase
        end
      end
      BDSL_ADDR: begin
        if (field_done) begin
          state_next = (cls_reg == CL_HWR) ? BDSL_EXEC : BDSL_WDATA;
        end
      end
      BDSL_WDATA: begin
        if (field_done) begin
          state_next = BDSL_EXEC;
        end
      end
      BDSL_EXEC: begin
        if (i_cpu_stopwait || abort) begin
          state_next = BDSL_OPC;
        end else if (done) begin
          state_next = ack_go ? BDSL_ACKDLY :
                       (is_read ? BDSL_RDATA : BDSL_OPC);
        end
      end
      BDSL_ACKDLY: begin
        if (abort) begin
          state_next = BDSL_OPC;
        end else if (!ack_go) begin
          state_next = is_read ? BDSL_RDATA : BDSL_OPC;
        end else if (dly_reg >= ACK_MIN_DELAY) begin
          state_next = BDSL_ACK;
        end
      end
      BDSL_ACK: begin
        if (tick && tcnt_reg == ACK_LOW_TICKS) begin
          state_next = is_read ? BDSL_RDATA : BDSL_OPC;
        end
      end
      BDSL_RDATA: begin
        if (field_done) begin
          state_next = BDSL_OPC;
        end
      end
      default: state_next = BDSL_OPC;
    endcase
    if (to_hit) begin
      state_next = BDSL_OPC;
    end
  end

  // ----------------------------------------------------------------
  // Bit engine, data path and pin drive
  // ----------------------------------------------------------------
  always_comb begin
    div_next = (tick || i_serial_clock_select) ? 2'h0 : div_reg + 2'h1;
    tcnt_next = tcnt_reg;
    bact_next = bact_reg;
    if (start_bit) begin
      tcnt_next = 5'h00;
      bact_next = 1'b1;
    end else if (tick && (bact_reg || state_reg == BDSL_ACK)) begin
      tcnt_next = tnext;
    end
    if (bit_done) begin
      bact_next = 1'b0;
    end
    if (state_next == BDSL_ACK && state_reg != BDSL_ACK) begin
      tcnt_next = 5'h00;
    end
    bitn_next = bit_done ? bitn_reg + 4'h1 : bitn_reg;
    if (state_next != state_reg || to_hit) begin
      bitn_next = 4'h0;
      bact_next = 1'b0;
    end
    hi8_next = at_tick(tick, bact_reg, tnext, GLITCH_TICK) ? sync2_reg :
               hi8_reg;
    sh_next = sh_reg;
    if (rx_state && at_tick(tick, bact_reg, tnext, SAMPLE_TICK)) begin
      sh_next = {sh_reg[14:0], sync2_reg && hi8_reg};
    end else if (tx_state && bit_done) begin
      sh_next = {sh_reg[14:0], 1'b0};
    end else if (state_reg == BDSL_EXEC && done && is_read) begin
      sh_next = rd_word;
    end
    op_next = (state_reg == BDSL_OPC && field_done) ? sh_reg[7:0] : op_reg;
    addr_next = (state_reg == BDSL_ADDR && field_done) ? sh_reg : addr_reg;
    wdat_next = (state_reg == BDSL_WDATA && field_done) ? sh_reg : wdat_reg;
    // Gap since command end
    dly_next = dly_reg;
    if (field_done) begin
      dly_next = 6'h00;
    end else if (tick && dly_reg != DELAY_MAX) begin
      dly_next = dly_reg + 6'h01;
    end
    to_next = (fall || !shift_state || to_hit) ? 10'h000 :
              (tick ? to_reg + 10'h001 : to_reg);
    bus_req_next = state_next == BDSL_EXEC && is_hw && !blocked_wr &&
                   !i_ext_wait && !hw_done && state_reg == BDSL_EXEC;
    // Raised only once settled in EXEC, so opcode output is current
    fw_req_next = state_next == BDSL_EXEC && !is_hw && !fw_done &&
                  state_reg == BDSL_EXEC;
    pin_out_next = 1'b0;
    pin_oe_next = 1'b0;
    if (tx_state && bact_reg) begin
      if (sh_reg[15]) begin
        pin_oe_next = tcnt_reg == ONE_PULSE_TICK;
        pin_out_next = 1'b1;
      end else begin
        pin_oe_next = tcnt_reg <= ZERO_LOW_TICKS;
        pin_out_next = tcnt_reg == ZERO_LOW_TICKS;
      end
    end else if (state_reg == BDSL_ACK) begin
      pin_oe_next = 1'b1;
      pin_out_next = tcnt_reg == ACK_LOW_TICKS;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Serial engine state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= BDSL_OPC;
      cls_reg <= CL_NONE;
      div_reg <= 2'h0;
      tcnt_reg <= 5'h00;
      bact_reg <= 1'b0;
      bitn_reg <= 4'h0;
      sh_reg <= 16'h0000;
      hi8_reg <= 1'b0;
      dly_reg <= 6'h00;
      to_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      cls_reg <= cls_next;
      div_reg <= div_next;
      tcnt_reg <= tcnt_next;
      bact_reg <= bact_next;
      bitn_reg <= bitn_next;
      sh_reg <= sh_next;
      hi8_reg <= hi8_next;
      dly_reg <= dly_next;
      to_reg <= to_next;
    end
  end

  // Command fields and outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      op_reg <= 8'h00;
      addr_reg <= 16'h0000;
      wdat_reg <= 16'h0000;
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
      o_bus_req <= 1'b0;
      o_bus_we <= 1'b0;
      o_bus_map <= 1'b0;
      o_bus_addr <= 16'h0000;
      o_bus_be <= 2'h0;
      o_bus_wdata <= 16'h0000;
      o_fw_req <= 1'b0;
      o_fw_opcode <= 8'h00;
      o_fw_wdata <= 16'h0000;
      o_timeout <= 1'b0;
    end else begin
      op_reg <= op_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      o_pin_out <= pin_out_next;
      o_pin_oe <= pin_oe_next;
      o_bus_req <= bus_req_next;
      o_bus_we <= cls_reg == CL_HWW;
      o_bus_map <= op_reg[OP_MAP_BIT];
      o_bus_addr <= even_addr;
      o_bus_be <= is_word ? 2'h3 : (addr_reg[0] ? 2'h1 : 2'h2);
      o_bus_wdata <= wdat_reg;
      o_fw_req <= fw_req_next;
      o_fw_opcode <= op_reg;
      o_fw_wdata <= wdat_reg;
      o_timeout <= to_hit;
    end
  end

endmodule // bdsl_link

// ==== bdsl_pkg.sv ====
// Constants and types shared by the single-wire debug link target
package bdsl_pkg;

  // ----------------------------------------------------------------
  // Serial bit timing, in target clock ticks
  // ----------------------------------------------------------------
  localparam logic [4:0] BIT_TICKS = 5'h10;      // Ticks in one bit time
  localparam logic [4:0] SAMPLE_TICK = 5'h0A;    // Host bit sampled here
  localparam logic [4:0] GLITCH_TICK = 5'h08;    // A one must be high here
  localparam logic [4:0] ONE_PULSE_TICK = 5'h07; // Speedup for a sent one
  localparam logic [4:0] ZERO_LOW_TICKS = 5'h0D; // Low time of a sent zero
  localparam logic [4:0] ACK_LOW_TICKS = 5'h10;  // Low time of handshake
  localparam logic [5:0] ACK_MIN_DELAY = 6'h20;  // Least gap before handshake
  localparam logic [5:0] DELAY_MAX = 6'h3F;      // Saturation of that gap
  localparam logic [9:0] TIMEOUT_TICKS = 10'h200; // Ticks between edges
  localparam logic [3:0] OPC_LAST_BIT = 4'h7;    // Opcode is 8 bits
  localparam logic [3:0] WORD_LAST_BIT = 4'hF;   // Address/data is 16 bits
  localparam logic [1:0] ALT_DIV_LAST = 2'h1;    // Alternate clock = clk/2

  // ----------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------
  localparam logic [3:0] HW_READ_TOP = 4'hE;
  localparam logic [3:0] HW_WRITE_TOP = 4'hC;
  localparam logic [1:0] HW_LOW_BITS = 2'h0;
  localparam logic [4:0] FW_READ_TOP = 5'h0C;
  localparam logic [4:0] FW_WRITE_TOP = 5'h08;
  localparam logic [2:0] FW_REG_MIN = 3'h2;
  localparam logic [7:0] OPC_GO = 8'h08;
  localparam logic [7:0] OPC_GO_UNTIL = 8'h0C;
  localparam logic [7:0] OPC_STEP = 8'h10;
  localparam logic [7:0] OPC_GO_OLD = 8'h18;
  localparam int OP_MAP_BIT = 2;   // Debug map selected
  localparam int OP_WORD_BIT = 3;  // Word rather than byte

  // Debug firmware area inside the debug map; writes there are dropped
  localparam logic [15:0] FW_AREA_LO = 16'hFF20;
  localparam logic [15:0] FW_AREA_HI = 16'hFFFF;

  typedef enum logic [2:0] {
    BDSL_OPC = 3'b000,
    BDSL_ADDR = 3'b001,
    BDSL_WDATA = 3'b010,
    BDSL_EXEC = 3'b011,
    BDSL_ACKDLY = 3'b100,
    BDSL_ACK = 3'b101,
    BDSL_RDATA = 3'b110
  } bdsl_state_t;

  typedef enum logic [2:0] {
    CL_NONE = 3'b000,
    CL_HWR = 3'b001,
    CL_HWW = 3'b010,
    CL_FWR = 3'b011,
    CL_FWW = 3'b100,
    CL_CTL = 3'b101
  } bdsl_cls_t;

endpackage : bdsl_pkg

// ==== bdsl_link_chk.sv ====
// Port-level checker for the debug link target
module bdsl_link_chk
  import bdsl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic o_pin_out,
  input wire logic o_pin_oe,
  input wire logic i_system_stop,
  input wire logic i_ext_wait,
  input wire logic o_bus_req,
  input wire logic o_bus_we,
  input wire logic o_bus_map,
  input wire logic [15:0] o_bus_addr,
  input wire logic i_bus_ack,
  input wire logic o_timeout
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic drv_lo;
  logic drv_hi;
  logic [10:0] idle_cnt;
  logic [10:0] lo_cnt;
  // Device drive levels
  assign drv_lo = o_pin_oe && !o_pin_out;
  assign drv_hi = o_pin_oe && o_pin_out;
  // Cycles since pin was low, length of device low drive
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt <= 11'h000;
      lo_cnt <= 11'h000;
    end else begin
      idle_cnt <= i_pin ? idle_cnt + {10'h000, ~&idle_cnt} : 11'h000;
      lo_cnt <= drv_lo ? lo_cnt + 11'h001 : 11'h000;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // End of a device low drive
  sequence s_low_end;
    drv_lo ##1 !drv_lo;
  endsequence
  AST_SPEEDUP_SHORT: assert property (not (drv_hi [*3]))
    else $error("device speedup lasts over two cycles");
  AST_LOW_MIN: assert property ($rose(drv_lo) |-> drv_lo [*8])
    else $error("device low drive too short");
  AST_LOW_MAX: assert property (lo_cnt <= 11'h020)
    else $error("device low drive too long");
  AST_LOW_ENDS_HIGH: assert property (s_low_end |-> drv_hi)
    else $error("device low drive ends without speedup");
  AST_EVEN_ADDR: assert property (o_bus_req |-> !o_bus_addr[0])
    else $error("bus address is odd");
  AST_REQ_HOLD: assert property (
    o_bus_req && !i_bus_ack && !i_ext_wait |=>
    o_bus_req && $stable(o_bus_addr))
    else $error("bus request changed before answer");
  AST_NO_STEAL: assert property ($past(i_ext_wait) |-> !o_bus_req)
    else $error("bus request during external wait");
  AST_FW_AREA: assert property (
    o_bus_req && o_bus_we && o_bus_map |-> o_bus_addr < FW_AREA_LO)
    else $error("write reached firmware area");
  AST_TIMEOUT_GAP: assert property (o_timeout |-> idle_cnt >= 11'h180)
    else $error("timeout too soon after pin activity");
  AST_STOP_NO_ACK: assert property (
    i_system_stop && $rose(drv_lo) |-> idle_cnt <= 11'h004)
    else $error("handshake started in system stop");
endmodule // bdsl_link_chk

bind bdsl_link bdsl_link_chk i_bdsl_link_chk (
  .i_clock, .i_rst, .i_pin, .o_pin_out, .o_pin_oe, .i_system_stop,
  .i_ext_wait, .o_bus_req, .o_bus_we, .o_bus_map, .o_bus_addr,
  .i_bus_ack, .o_timeout
);

// ==== bdsl_host.sv ====
// Behavioural debug host pod on the single wire
module bdsl_host (
  input wire logic i_clock,
  input wire logic i_pin,
  output logic o_oe,
  output logic o_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin released at start
  initial begin
    o_oe = 1'b0;
    o_out = 1'b1;
  end
  task automatic tx(input logic [15:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      @(negedge i_clock);
      o_oe = 1'b1;
      o_out = 1'b0;
      repeat (v[k] ? 4 : 14) @(negedge i_clock);
      o_out = 1'b1;
      @(negedge i_clock);
      o_oe = 1'b0;
      repeat (v[k] ? 16 : 6) @(negedge i_clock);
    end
  endtask
  task automatic rx(output logic [15:0] v);
    for (int k = 15; k >= 0; k--) begin
      @(negedge i_clock);
      o_oe = 1'b1;
      o_out = 1'b0;
      repeat (2) @(negedge i_clock);
      o_oe = 1'b0;
      repeat (8) @(negedge i_clock);
      v[k] = i_pin;
      repeat (12) @(negedge i_clock);
    end
  endtask
  task automatic ack(input int lim, output logic seen);
    int n;
    for (n = 0; n < lim && i_pin; n++) begin
      @(negedge i_clock);
    end
    seen = !i_pin;
    for (n = 0; n < 40 && !i_pin; n++) begin
      @(negedge i_clock);
    end
    repeat (4) @(negedge i_clock);
  endtask
endmodule // bdsl_host

// ==== tb_top.sv ====
// Self-checking bench for the debug link target
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, sel, stop, stopwait, ext_wait, bus_ack, fw_done, pin;
  logic pin_out, pin_oe, bus_req, bus_we, bus_map, fw_req, tmo, h_oe, h_out;
  logic [1:0] bus_be;
  logic [3:0] c_flags;
  logic [7:0] fw_opc, c_op;
  logic [15:0] bus_addr, bus_wdata, fw_wdata, c_addr, c_wd, c_fwd, n_bus;
  int failures, n_checks;
  // Open-drain wire with pull-up
  assign pin = !((h_oe && !h_out) || (pin_oe && !pin_out));
  bdsl_link i_bdsl_link (
    .i_clock(clk), .i_rst(rst), .i_serial_clock_select(sel), .i_pin(pin),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_ack_enable(1'b1),
    .i_system_stop(stop), .i_cpu_stopwait(stopwait), .i_ext_wait(ext_wait),
    .o_bus_req(bus_req), .o_bus_we(bus_we), .o_bus_map(bus_map),
    .o_bus_addr(bus_addr), .o_bus_be(bus_be), .o_bus_wdata(bus_wdata),
    .i_bus_ack(bus_ack), .i_bus_rdata(bus_addr ^ 16'hA5C3),
    .o_fw_req(fw_req), .o_fw_opcode(fw_opc), .o_fw_wdata(fw_wdata),
    .i_fw_done(fw_done), .i_fw_rdata({fw_opc, 8'h5A}), .o_timeout(tmo)
  );
  bdsl_host i_bdsl_host (
    .i_clock(clk), .i_pin(pin), .o_oe(h_oe), .o_out(h_out)
  );
  // bus and firmware answer, bus held off in wait
  always @(negedge clk) begin
    bus_ack <= bus_req && !bus_ack && !ext_wait;
    fw_done <= fw_req && !fw_done;
  end
  // Capture each completed access
  always @(posedge clk) begin
    if (rst) begin
      n_bus <= 16'h0000;
    end else if (bus_ack) begin
      c_addr <= bus_addr;
      c_wd <= bus_wdata;
      c_flags <= {bus_we, bus_map, bus_be};
      n_bus <= n_bus + 16'h0001;
    end
    if (fw_done) begin
      c_op <= fw_opc;
    end
    if (fw_done && fw_opc[6] && !fw_opc[5]) begin
      c_fwd <= fw_wdata;
    end
  end
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Cycles to the next timeout pulse, bounded
  task automatic wait_to(output logic [15:0] n);
    @(negedge clk);
    for (n = 16'h0001; tmo !== 1'b1; n++) begin
      @(negedge clk);
      if (n == 16'h0BB8) begin
        failures++;
        complete_run();
      end
    end
  endtask
  // Hardware reads and writes, misaligned and debug map
  task automatic t_hw();
    logic [7:0] op[7] = '{8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hC8, 8'hC4,
      8'hC4};
    logic [15:0] ad[7] = '{16'h1234, 16'h1235, 16'h1235, 16'hFF02,
      16'h1235, 16'hFF31, 16'h0101};
    logic [15:0] d, e, b0;
    logic [3:0] f;
    logic s;
    for (int k = 0; k < 7; k++) begin
      b0 = n_bus;
      i_bdsl_host.tx({8'h00, op[k]}, 8);
      i_bdsl_host.tx(ad[k], 16);
      if (!op[k][5]) begin
        i_bdsl_host.tx(16'hA55A, 16);
      end
      i_bdsl_host.ack(400, s);
      f[1:0] = op[k][3] ? 2'h3 : (ad[k][0] ? 2'h1 : 2'h2);
      f[3:2] = {!op[k][5], op[k][2]};
      e = ({ad[k][15:1], 1'b0} ^ 16'hA5C3) & {{8{f[1]}}, {8{f[0]}}};
      chk("hw ack", 16'h0001, {15'h0, s});
      chk("hw bus count", {15'h0, k != 5}, n_bus - b0);
      if (k != 5) begin
        chk("hw addr", {ad[k][15:1], 1'b0}, c_addr);
        chk("hw flags", {12'h0, f}, {12'h0, c_flags});
      end
      if (op[k][5]) begin
        i_bdsl_host.rx(d);
        chk("hw read data", e, d);
      end else if (k != 5) begin
        chk("hw write data", 16'hA55A, c_wd);
      end
      repeat (160) @(negedge clk);
    end
  endtask
  // Firmware read, write, step and resume
  task automatic t_fw();
    logic [7:0] op[4] = '{8'h63, 8'h45, 8'h10, 8'h0C};
    logic [15:0] d;
    logic s;
    for (int k = 0; k < 4; k++) begin
      i_bdsl_host.tx({8'h00, op[k]}, 8);
      if (op[k][6] && !op[k][5]) begin
        i_bdsl_host.tx(16'h0F0F, 16);
      end
      i_bdsl_host.ack(400, s);
      if (op[k][5]) begin
        i_bdsl_host.rx(d);
        chk("fw read data", {op[k], 8'h5A}, d);
      end
      repeat (80) @(negedge clk);
      chk("fw ack", 16'h0001, {15'h0, s});
      chk("fw opcode", {8'h00, op[k]}, {8'h00, c_op});
    end
    chk("fw write data", 16'h0F0F, c_fwd);
  endtask
  // System stop and CPU stop suppress the handshake
  task automatic t_stop();
    logic [15:0] d;
    logic s;
    stop = 1'b1;
    i_bdsl_host.tx(16'h0062, 8);
    i_bdsl_host.ack(200, s);
    chk("stop ack", 16'h0000, {15'h0, s});
    i_bdsl_host.rx(d);
    chk("stop read data", 16'h625A, d);
    stop = 1'b0;
    stopwait = 1'b1;
    i_bdsl_host.tx(16'h0044, 8);
    i_bdsl_host.tx(16'h3C3C, 16);
    i_bdsl_host.ack(200, s);
    chk("stopwait ack", 16'h0000, {15'h0, s});
    stopwait = 1'b0;
    repeat (80) @(negedge clk);
    chk("stopwait write dropped", 16'h0F0F, c_fwd);
  endtask
  // External wait holds the bus access back
  task automatic t_ext_wait();
    logic [15:0] d, b0;
    logic s;
    ext_wait = 1'b1;
    b0 = n_bus;
    i_bdsl_host.tx(16'h00E8, 8);
    i_bdsl_host.tx(16'h2000, 16);
    repeat (300) @(negedge clk);
    chk("bus held off", 16'h0000, n_bus - b0);
    ext_wait = 1'b0;
    i_bdsl_host.ack(400, s);
    i_bdsl_host.rx(d);
    chk("late read ack", 16'h0001, {15'h0, s});
    chk("late read data", 16'h2000 ^ 16'hA5C3, d);
  endtask
  // Idle timeout at both target clock rates
  task automatic t_timeout();
    logic [15:0] n, lo;
    logic ok;
    for (int k = 0; k < 2; k++) begin
      sel = (k == 0);
      lo = (k == 0) ? 16'h0200 : 16'h0400;
      wait_to(n);
      wait_to(n);
      ok = n + 16'h0004 >= lo && n <= lo + 16'h0004;
      chk("timeout gap", 16'h0001, {15'h0, ok});
    end
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    sel = 1'b1;
    stop = 1'b0;
    stopwait = 1'b0;
    ext_wait = 1'b0;
    bus_ack = 1'b0;
    fw_done = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_hw();
    t_fw();
    t_stop();
    t_ext_wait();
    t_timeout();
    complete_run();
  end
endmodule // tb_top
